// File: adsp_pkg.sv
// types shared by the converter serial ready port
package adsp_pkg;
  // shifter state, binary codes
  typedef enum logic [0:0] {
    ADSP_IDLE  = 1'b0,
    ADSP_SHIFT = 1'b1
  } adsp_state_t;

  // pins driven toward the reading party
  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic serial_result_out;
    logic sdo_oe;
    logic rdy_n;
  } adsp_pins_t;
endpackage

// File: adsp_port.sv
// serial output port and ready flag of a 16-bit converter
`timescale 1ns/1ns
`default_nettype none
`include "adsp_regs.svh"

// Behaviour
// RULE1 - role strap sets shift clock direction
// RULE2 - self-clocked: shift clock from master clock
// RULE3 - external mode: reader supplies the shift clock
// RULE4 - driven shift clock floats while deselected
// RULE5 - conversion end loads word, ready low
// RULE6 - ready high after all bits shifted
// RULE7 - deselected unread: ready high two cycles early
// RULE8 - external, selected, unread: ready high early
// RULE9 - msb first, advance on rising shift clock
// RULE10 - strap high master, strap low slave
// RULE11 - data output floats while deselected
// RULE12 - convert low starts; held low restarts
// RULE13 - reader waits ready, selects, clocks sixteen
module adsp_port
  import adsp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic serial_role_select_i, // strap pin
  input wire logic cs_n_i, // port select pin
  input wire logic sclk_i, // shift clock pin, external mode
  input wire logic convert_start_n_i, // convert pin
  input wire logic [`ADSP_WORD_W-1:0] convert_start_n_result_i, // result from the core
  output var adsp_pins_t pins_o, // port pins toward the reader
  output var logic convert_start_n_busy_o // conversion running
);

  // pin synchronisers, one bit each
  logic [`ADSP_SYNC_W-1:0] pin_raw;
  logic [`ADSP_SYNC_W-1:0] sync1_q;
  logic [`ADSP_SYNC_W-1:0] sync2_q;
  assign pin_raw = {serial_role_select_i, cs_n_i, sclk_i, convert_start_n_i};
  // reset levels match each pin's idle level; clock idles low, so no false rise
  logic [`ADSP_SYNC_W-1:0] sync_rst_w;
  assign sync_rst_w = `ADSP_SYNC_RST;

  genvar gi;
  generate
    for (gi = 0; gi < `ADSP_SYNC_W; gi++) begin : g_sync
      // two flops per pin; the first is read only by the second
      always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
          sync1_q[gi] <= sync_rst_w[gi];
          sync2_q[gi] <= sync_rst_w[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic convert_start_n_s; // synchronised convert level
  logic sclk_s; // synchronised external shift clock
  logic cs_s; // synchronised port select
  logic role_s; // synchronised strap
  assign convert_start_n_s = sync2_q[0];
  assign sclk_s = sync2_q[1];
  assign cs_s = sync2_q[2];
  assign role_s = sync2_q[3];

  // strap capture once the synchronisers hold the pin, then frozen
  logic role_q; // 1 = self-clocked master
  logic strap_taken_q;
  logic [`ADSP_STRAP_WAIT_W-1:0] strap_cnt_q; // edges since release
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      role_q <= 1'b0;
      strap_taken_q <= 1'b0;
      strap_cnt_q <= '0;
    end else if (!strap_taken_q) begin
      // synchronised copy shows its reset level for two edges; skip them
      if (strap_cnt_q == `ADSP_STRAP_WAIT_W'(`ADSP_STRAP_WAIT)) begin
        role_q <= role_s; // RULE10
        strap_taken_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + `ADSP_STRAP_WAIT_W'(1);
      end
    end
  end

  // conversion timer stands in for the converter core
  logic busy_q;
  logic [`ADSP_CONVERT_START_N_CNT_W-1:0] convert_start_n_cnt_q;
  logic start_w; // new conversion accepted
  logic done_w; // result available this cycle
  logic early_pt_w; // two master cycles before result
  assign start_w = !busy_q && !convert_start_n_s;
  assign done_w = busy_q &&
    (convert_start_n_cnt_q == `ADSP_CONVERT_START_N_CNT_W'(`ADSP_CONVERT_START_N_CYCLES - 1));
  assign early_pt_w = busy_q &&
    (convert_start_n_cnt_q == `ADSP_CONVERT_START_N_CNT_W'(`ADSP_CONVERT_START_N_CYCLES - 1 - `ADSP_EARLY_CYCLES));

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      convert_start_n_cnt_q <= '0;
    end else if (start_w) begin
      busy_q <= 1'b1; // RULE12
      convert_start_n_cnt_q <= '0;
    end else if (done_w) begin
      // convert still low as ready falls: go again
      busy_q <= !convert_start_n_s; // RULE12
      convert_start_n_cnt_q <= '0;
    end else if (busy_q) begin
      convert_start_n_cnt_q <= convert_start_n_cnt_q + `ADSP_CONVERT_START_N_CNT_W'(1);
    end
  end

  // shifter state
  adsp_state_t state_q;
  logic [`ADSP_WORD_W-1:0] word_q; // msb sits on the data pin
  logic [`ADSP_BIT_CNT_W-1:0] bits_left_q; // rising edges still owed
  logic started_q; // reader has begun clocking
  logic rdy_n_q;

  // self-clocked shift clock divider
  logic [`ADSP_DIV_W-1:0] div_q;
  logic sclk_q;
  logic int_run_w; // master clock may run
  logic int_rise_w; // internal shift clock rises now
  assign int_run_w = role_q && (state_q == ADSP_SHIFT) && !cs_s;
  assign int_rise_w = int_run_w && !sclk_q &&
    (div_q == `ADSP_DIV_W'(`ADSP_SCLK_HALF - 1));

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      div_q <= '0;
      sclk_q <= 1'b0;
    end else if (int_run_w) begin
      // rate follows the master clock only
      if (div_q == `ADSP_DIV_W'(`ADSP_SCLK_HALF - 1)) begin
        div_q <= '0;
        sclk_q <= !sclk_q; // RULE2
      end else begin
        div_q <= div_q + `ADSP_DIV_W'(1);
      end
    end else begin
      // park low so the next word starts with a clean rising edge
      div_q <= '0;
      sclk_q <= 1'b0;
    end
  end

  // external shift clock edge detect on the synchronised copy
  logic sclk_s_d_q;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sclk_s_d_q <= 1'b0;
    end else begin
      sclk_s_d_q <= sclk_s;
    end
  end

  logic ext_rise_w; // reader clock rises while selected
  logic rise_w; // one bit advances
  logic early_w; // unread word dropped early
  assign ext_rise_w = !role_q && !cs_s && sclk_s && !sclk_s_d_q; // RULE3
  assign rise_w = (state_q == ADSP_SHIFT) && (role_q ? int_rise_w : ext_rise_w);
  // reader clock must stay well under a quarter of the master clock
  assign early_w = early_pt_w && (state_q == ADSP_SHIFT) &&
    (cs_s || (!role_q && !started_q)); // RULE7 RULE8

  // word load, shifting and ready flag
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_q <= ADSP_IDLE;
      word_q <= `ADSP_WORD_RST;
      bits_left_q <= '0;
      started_q <= 1'b0;
      rdy_n_q <= 1'b1;
    end else if (done_w) begin
      // new result wins over any bit still in flight
      state_q <= ADSP_SHIFT;
      word_q <= convert_start_n_result_i; // RULE5
      bits_left_q <= `ADSP_BIT_CNT_W'(`ADSP_WORD_W);
      started_q <= 1'b0;
      rdy_n_q <= 1'b0; // RULE5
    end else if (early_w) begin
      state_q <= ADSP_IDLE;
      rdy_n_q <= 1'b1; // RULE7 RULE8
    end else if (rise_w) begin
      word_q <= {word_q[`ADSP_WORD_W-2:0], 1'b0}; // RULE9
      bits_left_q <= bits_left_q - `ADSP_BIT_CNT_W'(1);
      started_q <= 1'b1;
      if (bits_left_q == `ADSP_BIT_CNT_W'(1)) begin
        state_q <= ADSP_IDLE;
        rdy_n_q <= 1'b1; // RULE6
      end
    end
  end

  // output enables follow select and strap
  logic sdo_oe_q;
  logic sclk_oe_q;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sdo_oe_q <= 1'b0;
      sclk_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= !cs_s; // RULE11
      sclk_oe_q <= role_q && !cs_s; // RULE1 RULE4
    end
  end

  assign pins_o = '{sclk: sclk_q, sclk_oe: sclk_oe_q, serial_result_out: word_q[`ADSP_WORD_W-1],
                    sdo_oe: sdo_oe_q, rdy_n: rdy_n_q};
  assign convert_start_n_busy_o = busy_q;

  // checks
  property p_clk_dir;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    pins_o.sclk_oe |-> role_q;
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("shift clock driven in slave role"); // RULE1

  property p_clk_float;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    cs_s |=> !pins_o.sclk_oe;
  endproperty
  a_clk_float: assert property (p_clk_float) else $error("shift clock driven while deselected"); // RULE4

  property p_sdo_float;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    cs_s ##1 cs_s |=> !pins_o.sdo_oe;
  endproperty
  a_sdo_float: assert property (p_sdo_float) else $error("data driven while deselected"); // RULE11

  property p_load;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    done_w |=> !pins_o.rdy_n && word_q == $past(convert_start_n_result_i);
  endproperty
  a_load: assert property (p_load) else $error("result not loaded with ready low"); // RULE5

  property p_last_bit;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    rise_w && bits_left_q == `ADSP_BIT_CNT_W'(1) && !done_w |=> pins_o.rdy_n;
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("ready low after last bit"); // RULE6

  property p_early;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    early_w |=> pins_o.rdy_n ##1 pins_o.rdy_n ##1 !pins_o.rdy_n;
  endproperty
  a_early: assert property (p_early) else $error("ready not released two cycles early"); // RULE7 RULE8

  property p_msb_shift;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    rise_w && !done_w && !early_w |=>
      word_q == {$past(word_q[`ADSP_WORD_W-2:0]), 1'b0};
  endproperty
  a_msb_shift: assert property (p_msb_shift) else $error("data did not advance msb first"); // RULE9

  logic busy_o_chk; // busy raised with a fresh count
  assign busy_o_chk = convert_start_n_busy_o && convert_start_n_cnt_q == '0;
  property p_start;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    start_w |=> busy_o_chk;
  endproperty
  a_start: assert property (p_start) else $error("convert low did not start"); // RULE12

  property p_slave_quiet;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    strap_taken_q && !role_q |-> !pins_o.sclk && !pins_o.sclk_oe;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives shift clock"); // RULE10

  c_load: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) done_w);
  c_full_read: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rise_w && bits_left_q == `ADSP_BIT_CNT_W'(1));
  c_early: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) early_w);
endmodule
`default_nettype wire

// File: adsp_reader.sv
// partner model: a reader that selects the port and collects one word
`timescale 1ns/1ns
`default_nettype none
module adsp_reader
  import adsp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic start_i, // begin one read
  input wire logic ext_mode_i, // reader makes the shift clock
  input var adsp_pins_t pins_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [15:0] word_o,
  output logic done_o
);
  logic last; // bit seen just before a rise
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    word_o = 16'h0000;
    done_o = 1'b0;
  end
  // one frame per start pulse; the clock stays low outside frames
  always begin
    @(posedge start_i);
    @(negedge ref_clk_i);
    done_o = 1'b0;
    cs_n_o = 1'b0;
    for (int b = 0; b < 16; b++) begin
      if (ext_mode_i) begin
        // long low level, since sdo lags our rise by three cycles
        repeat (6) @(negedge ref_clk_i);
        word_o = {word_o[14:0], pins_i.serial_result_out};
        sclk_o = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        sclk_o = 1'b0;
      end else begin
        do begin
          last = pins_i.serial_result_out;
          @(negedge ref_clk_i);
        end while (!pins_i.sclk);
        word_o = {word_o[14:0], last};
        while (pins_i.sclk) @(negedge ref_clk_i);
      end
    end
    repeat (4) @(negedge ref_clk_i);
    cs_n_o = 1'b1;
    done_o = 1'b1;
  end
endmodule
`default_nettype wire

// File: adsp_regs.svh
// timing, width and reset constants for the converter serial ready port
`ifndef ADSP_REGS_SVH
`define ADSP_REGS_SVH
`define ADSP_WORD_W 16
`define ADSP_BIT_CNT_W 5
`define ADSP_CLK_PERIOD_NS 50
`define ADSP_CONVERT_START_N_TIME_NS 5000
`define ADSP_CONVERT_START_N_CYCLES ((`ADSP_CONVERT_START_N_TIME_NS + `ADSP_CLK_PERIOD_NS - 1) / `ADSP_CLK_PERIOD_NS)
`define ADSP_CONVERT_START_N_CNT_W 8
`define ADSP_EARLY_CYCLES 2
`define ADSP_SCLK_HALF 2
`define ADSP_DIV_W 2
`define ADSP_SYNC_W 4
`define ADSP_SYNC_RST 4'hD
`define ADSP_STRAP_WAIT 2
`define ADSP_STRAP_WAIT_W 2
`define ADSP_WORD_RST 16'h0000
`endif

// File: test_adsp_port.sv
// testbench for the converter serial ready port
`timescale 1ns/1ns
`default_nettype none
module test_adsp_port
  import adsp_pkg::*;
;
  logic ref_clk, resetn, role, convert_start_n_n, sel, start;
  logic [15:0] result;
  adsp_pins_t pins;
  logic busy, rd_cs_n, rd_sclk, rd_done;
  logic [15:0] rd_word;
  int error_cnt, samples_checked;
  // bench may hold select low with no frame running
  wire logic cs_n = rd_cs_n & ~sel;
  // shared clock wire: the port drives it when enabled, else the reader
  wire logic sclk_line = pins.sclk_oe ? pins.sclk : rd_sclk;

  adsp_port adsp_port_i (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .serial_role_select_i(role), .cs_n_i(cs_n), .sclk_i(sclk_line),
    .convert_start_n_i(convert_start_n_n), .convert_start_n_result_i(result), .pins_o(pins),
    .convert_start_n_busy_o(busy));
  adsp_reader adsp_reader_i (.ref_clk_i(ref_clk), .start_i(start),
    .ext_mode_i(~role), .pins_i(pins), .cs_n_o(rd_cs_n),
    .sclk_o(rd_sclk), .word_o(rd_word), .done_o(rd_done));

  always #25 ref_clk = ~ref_clk;

  task check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // bounded wait for the ready level
  task wait_rdy(input logic v, input int lim);
    int k;
    k = 0;
    while (pins.rdy_n !== v) begin
      if (k == lim) begin
        check(16'(pins.rdy_n), 16'(v));
        end_of_test;
      end
      cyc(1);
      k++;
    end
  endtask
  task do_reset(input logic r);
    role = r;
    resetn = 1'b0;
    cyc(6);
    resetn = 1'b1;
    cyc(4);
    check(16'(pins), 16'h0001);
  endtask
  task t_convert_start_n(input logic [15:0] val);
    result = val;
    convert_start_n_n = 1'b0;
    cyc(5);
    check(16'(busy), 16'h0001);
    convert_start_n_n = 1'b1;
    wait_rdy(1'b0, 120);
    check(16'(pins.sdo_oe), 16'h0000);
    check(16'(pins.sclk_oe), 16'h0000);
    $display("test convert_start_n done");
  endtask
  task t_read(input logic [15:0] val);
    int k;
    start = 1'b1;
    cyc(6);
    check(16'(pins.sclk_oe), 16'(role));
    check(16'(pins.sdo_oe), 16'h0001);
    start = 1'b0;
    k = 0;
    while (rd_done !== 1'b1 && k < 600) begin
      cyc(1);
      k++;
    end
    if (rd_done !== 1'b1) begin
      check(16'(rd_done), 16'h0001);
      end_of_test;
    end
    check(rd_word, val);
    check(16'(pins.rdy_n), 16'h0001);
    $display("test read done");
  endtask
  // convert held low, word left unread
  task t_early(input logic s);
    int n;
    sel = s;
    convert_start_n_n = 1'b0;
    wait_rdy(1'b0, 120);
    wait_rdy(1'b1, 120);
    n = 0;
    while (pins.rdy_n === 1'b1 && n < 10) begin
      n++;
      cyc(1);
    end
    check(16'(n), 16'h0002);
    if (n == 10) end_of_test;
    convert_start_n_n = 1'b1;
    sel = 1'b0;
    cyc(120);
    $display("test early done");
  endtask

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    role = 1'b1;
    convert_start_n_n = 1'b1;
    sel = 1'b0;
    start = 1'b0;
    result = 16'h0000;
    error_cnt = 0;
    samples_checked = 0;
    do_reset(1'b1);
    t_convert_start_n(16'hA5C3);
    t_read(16'hA5C3);
    t_early(1'b0);
    do_reset(1'b0);
    t_convert_start_n(16'h3C5A);
    t_read(16'h3C5A);
    t_early(1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
